// ==== hdl/acc_pkg.sv ====
package acc_pkg;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int INS_DEB_DEFAULT_MS = 90;
    localparam int REM_DEB_MS = 50;
    localparam int DET_MS = 2;
    localparam logic [1:0] DEB_SEL_RESET = 2'h1;
    localparam logic [7:0] SW_RESET = 8'h00;
    localparam int MANUAL_BIT = 6;
    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        ROUTE_NONE,
        ROUTE_3POLE,
        ROUTE_MIC_SLEEVE,
        ROUTE_MIC_RING2
    } route_t;
    typedef enum {
        ST_SLEEP,
        ST_INS_DEB,
        ST_DETECT,
        ST_ACTIVE,
        ST_REM_DEB
    } state_t;
endpackage

// ==== hdl/acc_tick_if.sv ====
`timescale 1ns/10ps
interface acc_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// ==== hdl/acc_tick_div.sv ====
`timescale 1ns/10ps
// Millisecond enable pulse from the system clock
module acc_tick_div #(
    parameter int CYCLES = acc_pkg::TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_N,
    acc_tick_if.src t
);
    logic [31:0] cnt_q;
    logic wrap;
    assign wrap = (cnt_q == 32'(CYCLES - 1));
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
        end
    end
    assign t.tick = wrap;
endmodule // acc_tick_div

// ==== hdl/acc_switch_ctrl.sv ====
`timescale 1ns/10ps
// Operation
// R1 - Insertion debounce defaults to 90 ms
// R2 - Host selects debounce from fixed set
// R3 - Detect mic contact, route bias and ground
// R4 - Key detect reports four keys press/release
// R5 - Sleep when empty and override clear
// R6 - Insertion in sleep wakes, detects, routes
// R7 - Sleep still takes settings and insertions
// R8 - Override set wakes; never with sleep
// R9 - Override clear when empty restores sleep
// R10 - Override enable is settings bit 6
// R11 - Sensing and detection run under override
// R12 - Switches frozen during any type detection
// R13 - Manual updates deferred during debounce
// R14 - Otherwise override applies switch registers
// R15 - Host writes switch registers before override
// R16 - Override clear restores last detection
// R17 - Detection starts from pin or command
// R18 - Removal debounce 50 ms then sleep
// R19 - Removal aborts any ongoing process
module acc_switch_ctrl #(
    parameter int TICK_CYCLES = acc_pkg::TICK_CYCLES
) (
    // System
    input wire logic CLK,
    input wire logic RST_N,
    // Jack pins
    input wire logic DETECT_N,
    input wire logic MIC_ON_SLEEVE,
    input wire logic MIC_ON_RING2,
    input wire logic [3:0] KEY_IN,
    // Host configuration
    input wire logic [7:0] SETTINGS1,
    input wire logic [1:0] DEB_SEL,
    input wire logic DEB_SEL_WE,
    input wire logic AUTO_DET_EN,
    input wire logic DET_CMD,
    input wire logic KEY_DET_EN,
    input wire logic [7:0] SW_REGS,
    // Switch and status outputs
    output logic [7:0] SW_STATE,
    output logic [1:0] ROUTE,
    output logic SLEEP,
    output logic INSERTED,
    output logic DET_DONE,
    output logic [7:0] KEY_EVENT
);
    // All checks below share this clock and reset
    default clocking sample_cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [6:0] sync1_q, sync2_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 7'h40;
            sync2_q <= 7'h40;
        end else begin
            sync1_q <= {DETECT_N, MIC_ON_SLEEVE, MIC_ON_RING2, KEY_IN};
            sync2_q <= sync1_q;
        end
    end
    logic det_pin, mic_s, mic_r;
    logic [3:0] keys;
    assign det_pin = ~sync2_q[6];
    assign mic_s = sync2_q[5];
    assign mic_r = sync2_q[4];
    assign keys = sync2_q[3:0];

    acc_tick_if tk ();
    acc_tick_div #(.CYCLES(TICK_CYCLES)) u_div (
        .CLK(CLK),
        .RST_N(RST_N),
        .t(tk.src)
    );

    // ********************************************************
    // Debounce selection, writable in any state
    // ********************************************************
    logic [1:0] deb_sel_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            deb_sel_q <= acc_pkg::DEB_SEL_RESET; // R1
        end else if (DEB_SEL_WE) begin
            deb_sel_q <= DEB_SEL; // R2 R7
        end
    end
    logic [7:0] ins_ms;
    // Fixed choices replace the external RC filter
    assign ins_ms = (deb_sel_q == 2'h0) ? 8'h1E :
                    (deb_sel_q == 2'h1) ? 8'h5A :
                    (deb_sel_q == 2'h2) ? 8'h78 : 8'hC8; // R2

    // ********************************************************
    // Sequencer
    // ********************************************************
    acc_pkg::state_t st_q, st_d;
    acc_pkg::route_t det_q, det_d;
    logic [7:0] ms_q, ms_d;
    logic det_valid_q, det_valid_d;
    logic manual;
    logic cmd_q;
    logic busy;
    assign manual = SETTINGS1[acc_pkg::MANUAL_BIT]; // R10
    assign busy = (st_q == acc_pkg::ST_INS_DEB) ||
                  (st_q == acc_pkg::ST_DETECT) ||
                  (st_q == acc_pkg::ST_REM_DEB); // R12 R13
    logic trig;
    // Pin debounce complete with auto detection enabled, or a host command, starts detection
    assign trig = AUTO_DET_EN || cmd_q; // R17

    always_comb begin
        st_d = st_q;
        det_d = det_q;
        ms_d = ms_q;
        det_valid_d = det_valid_q;
        case (st_q)
            acc_pkg::ST_SLEEP, acc_pkg::ST_REM_DEB: begin
                if (det_pin) begin
                    st_d = acc_pkg::ST_INS_DEB; // R6 R7
                    ms_d = 8'h0;
                end else if (st_q == acc_pkg::ST_REM_DEB && tk.tick) begin
                    ms_d = ms_q + 8'h1;
                    if (ms_q + 8'h1 >= 8'(acc_pkg::REM_DEB_MS)) begin
                        st_d = acc_pkg::ST_SLEEP; // R18
                    end
                end
            end
            acc_pkg::ST_INS_DEB: begin
                if (tk.tick) begin
                    ms_d = ms_q + 8'h1;
                    if (ms_q + 8'h1 >= ins_ms) begin
                        st_d = trig ? acc_pkg::ST_DETECT
                                    : acc_pkg::ST_ACTIVE;
                        ms_d = 8'h0;
                    end
                end
            end
            acc_pkg::ST_DETECT: begin
                if (tk.tick) begin
                    ms_d = ms_q + 8'h1;
                    if (ms_q + 8'h1 >= 8'(acc_pkg::DET_MS)) begin
                        st_d = acc_pkg::ST_ACTIVE;
                        det_valid_d = 1'b1;
                        det_d = mic_s ? acc_pkg::ROUTE_MIC_SLEEVE :
                                mic_r ? acc_pkg::ROUTE_MIC_RING2 :
                                acc_pkg::ROUTE_3POLE; // R3
                    end
                end
            end
            acc_pkg::ST_ACTIVE: begin
                if (cmd_q) begin
                    st_d = acc_pkg::ST_DETECT; // R17
                    ms_d = 8'h0;
                end
            end
            default: st_d = acc_pkg::ST_SLEEP;
        endcase
        // Removal overrides every other step
        if (!det_pin && st_q != acc_pkg::ST_SLEEP &&
                st_q != acc_pkg::ST_REM_DEB) begin
            st_d = acc_pkg::ST_REM_DEB; // R19
            ms_d = 8'h0;
            det_valid_d = 1'b0;
            det_d = acc_pkg::ROUTE_NONE;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= acc_pkg::ST_SLEEP;
            det_q <= acc_pkg::ROUTE_NONE;
            ms_q <= 8'h0;
            det_valid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            det_q <= det_d;
            ms_q <= ms_d;
            det_valid_q <= det_valid_d;
        end
    end

    // Command is held until detection starts, and is dropped in sleep
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_q <= 1'b0;
        end else if (DET_CMD) begin
            cmd_q <= 1'b1;
        end else if (st_q == acc_pkg::ST_DETECT ||
                     st_q == acc_pkg::ST_SLEEP) begin
            cmd_q <= 1'b0;
        end
    end

    // ********************************************************
    // Switch routing
    // ********************************************************
    logic [7:0] auto_sw;
    assign auto_sw = det_valid_q ? {6'h0, 2'(det_q)} : acc_pkg::SW_RESET;
    logic [7:0] sw_q;
    logic [1:0] route_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sw_q <= acc_pkg::SW_RESET;
            route_q <= 2'h0;
        end else if (!busy) begin
            // Frozen while detection or debounce is running
            sw_q <= manual ? SW_REGS : auto_sw; // R14 R16 R9 R11
            route_q <= det_valid_q ? 2'(det_q) : 2'h0;
        end
    end

    // Sleep only when empty with override clear
    logic sleep_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sleep_q <= 1'b1;
        end else begin
            sleep_q <= (st_d == acc_pkg::ST_SLEEP) && !manual; // R5 R8 R9
        end
    end

    // ********************************************************
    // Key press reporting
    // ********************************************************
    logic [3:0] key_prev_q;
    logic [7:0] key_ev_q;
    logic key_on;
    assign key_on = KEY_DET_EN && (st_q == acc_pkg::ST_ACTIVE) &&
                    det_valid_q && (det_q != acc_pkg::ROUTE_3POLE);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_prev_q <= 4'h0;
            key_ev_q <= 8'h00;
        end else begin
            key_prev_q <= key_on ? keys : 4'h0;
            for (int i = 0; i < 4; i++) begin
                key_ev_q[2*i] <= key_on & keys[i] & ~key_prev_q[i]; // R4
                key_ev_q[2*i+1] <= key_on & ~keys[i] & key_prev_q[i]; // R4
            end
        end
    end

    logic done_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (st_q == acc_pkg::ST_DETECT) &&
                      (st_d == acc_pkg::ST_ACTIVE);
        end
    end

    assign SW_STATE = sw_q;
    assign ROUTE = route_q;
    assign SLEEP = sleep_q;
    assign INSERTED = det_pin;
    assign DET_DONE = done_q;
    assign KEY_EVENT = key_ev_q;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_det_end;
        (st_q == acc_pkg::ST_DETECT) && (st_d == acc_pkg::ST_ACTIVE);
    endsequence
    sequence s_done_pulse;
        DET_DONE ##1 !DET_DONE;
    endsequence
    chk_sleep_manual: assert property ( // R8
        !(SLEEP && $past(manual))) else $error("sleep with override");
    chk_freeze_detect: assert property ( // R12
        $past(busy) |-> $stable(SW_STATE)) else $error("switch moved");
    chk_manual_apply: assert property ( // R14
        (!busy && manual) |=> (SW_STATE == $past(SW_REGS)))
        else $error("override not applied");
    chk_removal_abort: assert property ( // R19
        (!det_pin && (st_q == acc_pkg::ST_DETECT)) |=>
        (st_q == acc_pkg::ST_REM_DEB)) else $error("removal ignored");
    chk_cmd_detect: assert property ( // R17
        (cmd_q && det_pin && st_q == acc_pkg::ST_ACTIVE) |=>
        (st_q == acc_pkg::ST_DETECT)) else $error("command lost");
    chk_revert_empty: assert property ( // R16
        (!manual && !busy && !det_valid_q) |=>
        (SW_STATE == acc_pkg::SW_RESET)) else $error("no revert");
    chk_deb_reset: assert property ( // R1
        $rose(RST_N) |-> (deb_sel_q == acc_pkg::DEB_SEL_RESET))
        else $error("bad default");
    chk_key_gate: assert property ( // R4
        !$past(KEY_DET_EN) |-> (KEY_EVENT == 8'h00))
        else $error("key while off");
    chk_done_pulse: assert property ( // R6
        s_det_end |=> s_done_pulse) else $error("no done pulse");
endmodule // acc_switch_ctrl

// ==== tb/acc_headset.sv ====
`timescale 1ns/10ps
// Behavioural headset at the jack
module acc_headset #(
    parameter int BOUNCES = 3
) (
    // Bench control
    input wire logic plug,
    input wire logic [1:0] kind,
    input wire logic [3:0] keys,
    // Jack side
    output logic detect_n,
    output logic mic_sleeve,
    output logic mic_ring2,
    output logic [3:0] key_lvl
);
    // Contacts chatter on entry, so the debounce has to restart
    initial begin
        detect_n = 1'b1;
        forever begin
            @(plug);
            // Step off the clock edge so the pin never races the sampler
            #1;
            if (plug) begin
                repeat (BOUNCES) begin
                    detect_n = 1'b0;
                    #40 detect_n = 1'b1;
                    #40;
                end
            end
            detect_n = !plug;
        end
    end
    // Open jack: no mic seen, keys read released
    assign mic_sleeve = plug && kind == 2'h2;
    assign mic_ring2 = plug && kind == 2'h3;
    assign key_lvl = plug ? keys : 4'h0;
endmodule // acc_headset

// ==== tb/tb_acc_switch_ctrl.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_acc_switch_ctrl;
    localparam int T = 10;
    int dms[4] = '{30, 90, 120, 200};
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic plug = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] keys = 4'h0;
    logic DETECT_N, MIC_ON_SLEEVE, MIC_ON_RING2;
    logic [3:0] KEY_IN;
    logic [7:0] SETTINGS1 = 8'h00;
    logic [1:0] DEB_SEL = 2'h1;
    logic DEB_SEL_WE = 1'b0;
    logic AUTO_DET_EN = 1'b1;
    logic DET_CMD = 1'b0;
    logic KEY_DET_EN = 1'b0;
    logic [7:0] SW_REGS = 8'h00;
    logic [7:0] SW_STATE, KEY_EVENT;
    logic [1:0] ROUTE;
    logic SLEEP, INSERTED, DET_DONE;
    int errors = 0;
    int n_checks = 0;
    int n;
    always #2 CLK = ~CLK;
    acc_headset u_acc_headset (.plug(plug), .kind(kind), .keys(keys),
        .detect_n(DETECT_N), .mic_sleeve(MIC_ON_SLEEVE),
        .mic_ring2(MIC_ON_RING2), .key_lvl(KEY_IN));
    acc_switch_ctrl #(.TICK_CYCLES(T)) u_acc_switch_ctrl (.CLK(CLK),
        .RST_N(RST_N), .DETECT_N(DETECT_N), .MIC_ON_SLEEVE(MIC_ON_SLEEVE),
        .MIC_ON_RING2(MIC_ON_RING2), .KEY_IN(KEY_IN), .SETTINGS1(SETTINGS1),
        .DEB_SEL(DEB_SEL), .DEB_SEL_WE(DEB_SEL_WE), .AUTO_DET_EN(AUTO_DET_EN),
        .DET_CMD(DET_CMD), .KEY_DET_EN(KEY_DET_EN), .SW_REGS(SW_REGS),
        .SW_STATE(SW_STATE), .ROUTE(ROUTE), .SLEEP(SLEEP),
        .INSERTED(INSERTED), .DET_DONE(DET_DONE), .KEY_EVENT(KEY_EVENT));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic close_out();
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic nx(input int c);
        repeat (c) @(negedge CLK);
    endtask
    // Bounded wait: 0 done pulse, 1 asleep, 2 any key event
    task automatic wt(input int w, input int lim);
        n = 1;
        @(negedge CLK);
        while (n < lim && !(w == 0 ? DET_DONE === 1'b1 :
                w == 1 ? SLEEP === 1'b1 : KEY_EVENT !== 8'h00)) begin
            @(negedge CLK);
            n++;
        end
    endtask
    task automatic ins(input logic [1:0] k);
        @(posedge CLK);
        plug <= 1'b1;
        kind <= k;
    endtask
    // Switch values go in one cycle ahead of the override bit
    task automatic setsw(input logic ov, input logic [7:0] v);
        @(posedge CLK);
        SW_REGS <= v;
        @(posedge CLK);
        SETTINGS1 <= {1'b0, ov, 6'h00};
        nx(3);
    endtask
    task automatic rem();
        @(posedge CLK);
        plug <= 1'b0;
        wt(1, 60 * T);
        `CHK("sleep time", 1'b1, n >= 49 * T && n <= 52 * T)
        // Switches leave the removal freeze one cycle after sleep
        nx(2);
    endtask
    task automatic det(input logic [1:0] k, input int ms);
        ins(k);
        wt(0, (ms + 4) * T + 100);
        `CHK("det time", 1'b1, n >= (ms + 1) * T && n <= (ms + 3) * T + 70)
        nx(2);
        `CHK("route", k, ROUTE)
    endtask
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        nx(1);
        `CHK("sleep", 1'b1, SLEEP)
        `CHK("sw", 8'h00, SW_STATE)
        det(2'h1, 90);
        `CHK("sw", 8'h01, SW_STATE)
        `CHK("awake", 1'b0, SLEEP)
        `CHK("ins", 1'b1, INSERTED)
        rem();
        `CHK("route", 2'h0, ROUTE)
        for (int i = 3; i >= 0; i--) begin
            @(posedge CLK);
            DEB_SEL <= i[1:0];
            DEB_SEL_WE <= 1'b1;
            @(posedge CLK);
            DEB_SEL_WE <= 1'b0;
            det(2'(i % 3 + 1), dms[i]);
            `CHK("sw", 8'(i % 3 + 1), SW_STATE)
            rem();
        end
        det(2'h2, 30);
        @(posedge CLK);
        KEY_DET_EN <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            keys <= 4'h1 << i;
            wt(2, 40);
            `CHK("press", 8'h01 << 2 * i, KEY_EVENT)
            @(posedge CLK);
            keys <= 4'h0;
            wt(2, 40);
            `CHK("release", 8'h02 << 2 * i, KEY_EVENT)
        end
        setsw(1'b1, 8'hA5);
        `CHK("sw", 8'hA5, SW_STATE)
        setsw(1'b0, 8'hA5);
        `CHK("sw", 8'h02, SW_STATE)
        rem();
        setsw(1'b1, 8'hA5);
        `CHK("sleep", 1'b0, SLEEP)
        `CHK("sw", 8'hA5, SW_STATE)
        ins(2'h3);
        nx(15 * T);
        setsw(1'b1, 8'h5A);
        `CHK("sw", 8'hA5, SW_STATE)
        wt(0, 60 * T);
        `CHK("done", 1'b1, DET_DONE)
        nx(2);
        `CHK("route", 2'h3, ROUTE)
        `CHK("sw", 8'h5A, SW_STATE)
        @(posedge CLK);
        plug <= 1'b0;
        nx(60 * T);
        `CHK("sleep", 1'b0, SLEEP)
        setsw(1'b0, 8'h5A);
        `CHK("sleep", 1'b1, SLEEP)
        `CHK("sw", 8'h00, SW_STATE)
        @(posedge CLK);
        AUTO_DET_EN <= 1'b0;
        ins(2'h1);
        nx(40 * T);
        `CHK("sw", 8'h00, SW_STATE)
        setsw(1'b1, 8'hFF);
        `CHK("sw", 8'hFF, SW_STATE)
        setsw(1'b0, 8'hFF);
        `CHK("sw", 8'h00, SW_STATE)
        setsw(1'b1, 8'hFF);
        @(posedge CLK);
        DET_CMD <= 1'b1;
        @(posedge CLK);
        DET_CMD <= 1'b0;
        // Write lands once the latched command has started detection
        @(posedge CLK);
        SW_REGS <= 8'h3C;
        nx(3);
        `CHK("sw", 8'hFF, SW_STATE)
        wt(0, 40 * T);
        `CHK("done", 1'b1, DET_DONE)
        nx(2);
        `CHK("sw", 8'h3C, SW_STATE)
        setsw(1'b0, 8'h3C);
        `CHK("sw", 8'h01, SW_STATE)
        rem();
        @(posedge CLK);
        AUTO_DET_EN <= 1'b1;
        ins(2'h2);
        nx(10 * T);
        @(posedge CLK);
        plug <= 1'b0;
        wt(0, 60 * T);
        `CHK("done", 1'b0, DET_DONE)
        `CHK("sleep", 1'b1, SLEEP)
        det(2'h1, 30);
        @(posedge CLK);
        DET_CMD <= 1'b1;
        @(posedge CLK);
        DET_CMD <= 1'b0;
        plug <= 1'b0;
        wt(0, 60 * T);
        `CHK("done", 1'b0, DET_DONE)
        `CHK("sleep", 1'b1, SLEEP)
        close_out();
    end
endmodule // tb_acc_switch_ctrl
